// *** verilog/cmmd_params.svh ***
// constants for the core memory map decoder: offsets, fields, reset values
`ifndef CMMD_PARAMS_SVH
`define CMMD_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define CMMD_OFF_CTRL         8'h00
`define CMMD_OFF_PROBE_ADDR   8'h04
`define CMMD_OFF_PROBE_RESULT 8'h08
`define CMMD_OFF_CFG_STATUS   8'h0C

// ************************************************************
// field positions
// ************************************************************
`define CMMD_CTRL_DEC_EN_BIT  0
`define CMMD_RES_INSTR_BIT    0
`define CMMD_RES_DATA_BIT     1
`define CMMD_RES_INTC_BIT     2
`define CMMD_RES_NONE_BIT     3
`define CMMD_ST_VALID_BIT     0
`define CMMD_ST_ALIGN_BIT     1
`define CMMD_ST_SIZE_BIT      2
`define CMMD_ST_OVERLAP_BIT   3
`define CMMD_ST_BOUND_BIT     4

// ************************************************************
// reset values
// ************************************************************
`define CMMD_CTRL_RESET       32'h0000_0001
`define CMMD_PROBE_RESET      32'h0000_0000

// ************************************************************
// address map geometry
// ************************************************************
`define CMMD_KB_SHIFT         10
`define CMMD_REGION_SPAN      33'h0_1000_0000
`define CMMD_MIN_ALIGN        33'h0_0000_0400
`define CMMD_ALIGN_STEPS      23
`define CMMD_HTRANS_VALID_BIT 1

`endif

// *** verilog/cmmd_pkg.sv ***
// types shared by the core memory map decoder
package cmmd_pkg;
  typedef logic [31:0] cmmd_addr_t;
  typedef logic [3:0]  cmmd_region_t;
  typedef logic [27:0] cmmd_offset_t;
  typedef logic [32:0] cmmd_span_t;
endpackage

// *** verilog/cmmd_decoder.sv ***
// core memory map decoder: build checks, address claims and ahb-lite control and status registers
`include "cmmd_params.svh"

module cmmd_decoder #(
  parameter int unsigned           INSTR_LOCAL_MEM_PRESENT = 1,
  parameter cmmd_pkg::cmmd_region_t INSTR_LOCAL_MEM_REGION = 4'hE,
  parameter cmmd_pkg::cmmd_offset_t INSTR_LOCAL_MEM_OFFSET = 28'h000_0000,
  parameter int unsigned           INSTR_LOCAL_MEM_SIZE    = 512,
  parameter cmmd_pkg::cmmd_region_t DATA_LOCAL_MEM_REGION  = 4'hF,
  parameter cmmd_pkg::cmmd_offset_t DATA_LOCAL_MEM_OFFSET  = 28'h004_0000,
  parameter int unsigned           DATA_LOCAL_MEM_SIZE     = 64,
  parameter int unsigned           ICACHE_PRESENT          = 1,
  parameter int unsigned           ICACHE_CAPACITY         = 16,
  parameter int unsigned           ICACHE_PROTECT_SEL      = 0,
  parameter cmmd_pkg::cmmd_region_t INTC_REGBLOCK_REGION   = 4'hF,
  parameter cmmd_pkg::cmmd_offset_t INTC_REGBLOCK_OFFSET   = 28'h0C0_0000,
  parameter int unsigned           INTC_REGBLOCK_SIZE      = 32
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] fetch_addr,
  input  wire logic [31:0] ls_addr,
  output logic             fetch_instr_sel,
  output logic             ls_instr_sel,
  output logic             ls_data_sel,
  output logic             ls_intc_sel,
  output logic             ls_unclaimed,
  output logic             cfg_invalid,
  output logic             icache_present,
  output logic             icache_protect_sel
);

  // ************************************************************
  // build-time arithmetic
  // ************************************************************
  function automatic cmmd_pkg::cmmd_span_t kb_bytes(input int unsigned kb);
    kb_bytes = cmmd_pkg::cmmd_span_t'(kb) << `CMMD_KB_SHIFT;
  endfunction

  // smallest power of two not below the block size
  function automatic cmmd_pkg::cmmd_span_t align_of(input int unsigned kb);
    cmmd_pkg::cmmd_span_t p;
    p = `CMMD_MIN_ALIGN;
    for (int i = 0; i < `CMMD_ALIGN_STEPS; i++) begin
      if (p < kb_bytes(kb)) begin
        p = p << 1;
      end
    end
    align_of = p;
  endfunction

  function automatic logic misaligned(input cmmd_pkg::cmmd_offset_t off,
                                      input int unsigned kb);
    misaligned = ((cmmd_pkg::cmmd_span_t'(off) % align_of(kb)) != 33'h0_0000_0000);
  endfunction

  function automatic logic past_region(input cmmd_pkg::cmmd_offset_t off,
                                       input int unsigned kb);
    past_region = (cmmd_pkg::cmmd_span_t'(off) + kb_bytes(kb)) > `CMMD_REGION_SPAN;
  endfunction

  function automatic logic overlaps(input cmmd_pkg::cmmd_region_t r1,
                                    input cmmd_pkg::cmmd_offset_t o1,
                                    input int unsigned k1,
                                    input cmmd_pkg::cmmd_region_t r2,
                                    input cmmd_pkg::cmmd_offset_t o2,
                                    input int unsigned k2);
    cmmd_pkg::cmmd_span_t a1;
    cmmd_pkg::cmmd_span_t a2;
    a1 = cmmd_pkg::cmmd_span_t'(o1);
    a2 = cmmd_pkg::cmmd_span_t'(o2);
    overlaps = (r1 == r2) && (a1 < a2 + kb_bytes(k2)) && (a2 < a1 + kb_bytes(k1));
  endfunction

  // address claim: region bits, then low 28 bits inside offset..offset+size
  function automatic logic in_block(input cmmd_pkg::cmmd_addr_t a,
                                    input cmmd_pkg::cmmd_region_t r,
                                    input cmmd_pkg::cmmd_offset_t off,
                                    input int unsigned kb);
    cmmd_pkg::cmmd_span_t lo;
    cmmd_pkg::cmmd_span_t ad;
    lo = cmmd_pkg::cmmd_span_t'(off);
    ad = cmmd_pkg::cmmd_span_t'(a[27:0]);
    in_block = (a[31:28] == r) && (ad >= lo) && (ad < lo + kb_bytes(kb));
  endfunction

  // ************************************************************
  // build configuration checks
  // ************************************************************
  localparam logic INSTR_ON = (INSTR_LOCAL_MEM_PRESENT == 1);
  localparam logic ICACHE_ON = (ICACHE_PRESENT == 1);

  localparam logic SIZE_ERR =
    (INSTR_LOCAL_MEM_PRESENT > 1) || (ICACHE_PRESENT > 1) || (ICACHE_PROTECT_SEL > 1) ||
    (INSTR_ON && !(INSTR_LOCAL_MEM_SIZE inside {4, 8, 16, 32, 64, 128, 256, 512})) ||
    !(DATA_LOCAL_MEM_SIZE inside {4, 8, 16, 32, 48, 64, 128, 256, 512}) ||
    (ICACHE_ON && !(ICACHE_CAPACITY inside {16, 32, 64, 128, 256})) ||
    !(INTC_REGBLOCK_SIZE inside {32, 64, 128, 256});

  localparam logic ALIGN_ERR =
    (INSTR_ON && misaligned(INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE)) ||
    misaligned(DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE) ||
    misaligned(INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE);

  localparam logic BOUND_ERR =
    (INSTR_ON && past_region(INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE)) ||
    past_region(DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE) ||
    past_region(INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE);

  localparam logic OVERLAP_ERR =
    (INSTR_ON && overlaps(INSTR_LOCAL_MEM_REGION, INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE,
                          DATA_LOCAL_MEM_REGION, DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE)) ||
    (INSTR_ON && overlaps(INSTR_LOCAL_MEM_REGION, INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE,
                          INTC_REGBLOCK_REGION, INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE)) ||
    overlaps(DATA_LOCAL_MEM_REGION, DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE,
             INTC_REGBLOCK_REGION, INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE);

  localparam logic CFG_BAD = SIZE_ERR || ALIGN_ERR || BOUND_ERR || OVERLAP_ERR;

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] ctrl_r;
  logic [31:0] probe_addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  dp_addr_r;
  logic        fetch_instr_sel_r;
  logic        ls_instr_sel_r;
  logic        ls_data_sel_r;
  logic        ls_intc_sel_r;
  logic        ls_unclaimed_r;
  logic        cfg_invalid_r;
  logic        icache_present_r;
  logic        icache_protect_r;
  logic        dec_en;
  logic        addr_phase;
  logic [31:0] probe_result;
  logic [31:0] cfg_status;
  logic [31:0] rd_value;

  assign dec_en     = ctrl_r[`CMMD_CTRL_DEC_EN_BIT];
  assign addr_phase = hsel && hready && htrans[`CMMD_HTRANS_VALID_BIT];

  // ************************************************************
  // ahb-lite slave: writes zero wait, reads one wait state
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      rd_pend_r <= addr_phase && !hwrite;
      if (addr_phase) begin
        dp_addr_r <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= !(addr_phase && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r       <= `CMMD_CTRL_RESET;
      probe_addr_r <= `CMMD_PROBE_RESET;
    end else if (wr_pend_r) begin
      if (dp_addr_r == `CMMD_OFF_CTRL) begin
        ctrl_r <= {31'h0000_0000, hwdata[`CMMD_CTRL_DEC_EN_BIT]};
      end
      if (dp_addr_r == `CMMD_OFF_PROBE_ADDR) begin
        probe_addr_r <= hwdata;
      end
    end
  end

  always_comb begin
    probe_result = 32'h0000_0000;
    probe_result[`CMMD_RES_INSTR_BIT] = INSTR_ON && in_block(probe_addr_r,
      INSTR_LOCAL_MEM_REGION, INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE);
    probe_result[`CMMD_RES_DATA_BIT] = in_block(probe_addr_r,
      DATA_LOCAL_MEM_REGION, DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE);
    probe_result[`CMMD_RES_INTC_BIT] = in_block(probe_addr_r,
      INTC_REGBLOCK_REGION, INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE);
    probe_result[`CMMD_RES_NONE_BIT] = (probe_result[2:0] == 3'h0);
    cfg_status = 32'h0000_0000;
    cfg_status[`CMMD_ST_VALID_BIT]   = !CFG_BAD;
    cfg_status[`CMMD_ST_ALIGN_BIT]   = ALIGN_ERR;
    cfg_status[`CMMD_ST_SIZE_BIT]    = SIZE_ERR;
    cfg_status[`CMMD_ST_OVERLAP_BIT] = OVERLAP_ERR;
    cfg_status[`CMMD_ST_BOUND_BIT]   = BOUND_ERR;
    unique case (dp_addr_r)
      `CMMD_OFF_CTRL:         rd_value = ctrl_r;
      `CMMD_OFF_PROBE_ADDR:   rd_value = probe_addr_r;
      `CMMD_OFF_PROBE_RESULT: rd_value = probe_result;
      `CMMD_OFF_CFG_STATUS:   rd_value = cfg_status;
      default:                rd_value = 32'h0000_0000;
    endcase
  end

  // read data loaded at the end of the wait state, after any prior write landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_value;
    end
  end

  // ************************************************************
  // address claims, one cycle after the address is presented
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_instr_sel_r <= 1'b0;
      ls_instr_sel_r    <= 1'b0;
      ls_data_sel_r     <= 1'b0;
      ls_intc_sel_r     <= 1'b0;
      ls_unclaimed_r    <= 1'b0;
    end else begin
      fetch_instr_sel_r <= dec_en && INSTR_ON && in_block(fetch_addr, INSTR_LOCAL_MEM_REGION,
                           INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE);
      ls_instr_sel_r    <= dec_en && INSTR_ON && in_block(ls_addr, INSTR_LOCAL_MEM_REGION,
                           INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE);
      ls_data_sel_r     <= dec_en && in_block(ls_addr, DATA_LOCAL_MEM_REGION,
                           DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE);
      ls_intc_sel_r     <= dec_en && in_block(ls_addr, INTC_REGBLOCK_REGION,
                           INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE);
      ls_unclaimed_r    <= dec_en &&
        !(INSTR_ON && in_block(ls_addr, INSTR_LOCAL_MEM_REGION, INSTR_LOCAL_MEM_OFFSET,
                               INSTR_LOCAL_MEM_SIZE)) &&
        !in_block(ls_addr, DATA_LOCAL_MEM_REGION, DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE) &&
        !in_block(ls_addr, INTC_REGBLOCK_REGION, INTC_REGBLOCK_OFFSET, INTC_REGBLOCK_SIZE);
    end
  end

  // ************************************************************
  // build options driven out
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_invalid_r    <= 1'b0;
      icache_present_r <= 1'b0;
      icache_protect_r <= 1'b0;
    end else begin
      cfg_invalid_r    <= CFG_BAD;
      icache_present_r <= ICACHE_ON;
      icache_protect_r <= ICACHE_ON && (ICACHE_PROTECT_SEL == 1);
    end
  end

  assign hrdata             = hrdata_r;
  assign hreadyout          = hreadyout_r;
  assign hresp              = 1'b0;
  assign fetch_instr_sel    = fetch_instr_sel_r;
  assign ls_instr_sel       = ls_instr_sel_r;
  assign ls_data_sel        = ls_data_sel_r;
  assign ls_intc_sel        = ls_intc_sel_r;
  assign ls_unclaimed       = ls_unclaimed_r;
  assign cfg_invalid        = cfg_invalid_r;
  assign icache_present     = icache_present_r;
  assign icache_protect_sel = icache_protect_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  build_valid_a: assert property ($past(hresetn) |->
                                 cfg_invalid_r == (cfg_status[4:1] != 4'h0))
    else $error("invalid flag disagrees with build error bits");
  instr_absent_a: assert property (!INSTR_ON |-> !fetch_instr_sel_r && !ls_instr_sel_r)
    else $error("absent instruction memory claimed an address");
  claim_onehot_a: assert property ($past(hresetn) && $past(dec_en) |->
                                   $onehot({ls_instr_sel_r, ls_data_sel_r, ls_intc_sel_r,
                                            ls_unclaimed_r}))
    else $error("load/store address claimed by more than one block");
  data_region_a: assert property (ls_data_sel_r |->
                                  $past(ls_addr[31:28]) == DATA_LOCAL_MEM_REGION)
    else $error("data memory claimed outside its region");
  data_range_a: assert property (ls_data_sel_r |->
    ({4'h0, $past(ls_addr[27:0])} - {4'h0, DATA_LOCAL_MEM_OFFSET}) <
    32'(DATA_LOCAL_MEM_SIZE) * 32'd1024)
    else $error("data memory claimed outside offset and size");
  intc_hit_a: assert property (dec_en && ls_addr[31:28] == INTC_REGBLOCK_REGION &&
                               ls_addr[27:0] == INTC_REGBLOCK_OFFSET |=> ls_intc_sel_r)
    else $error("interrupt register block start not claimed");
  fetch_hit_a: assert property (dec_en && INSTR_ON &&
    fetch_addr == {INSTR_LOCAL_MEM_REGION, INSTR_LOCAL_MEM_OFFSET} |=> fetch_instr_sel_r)
    else $error("instruction memory start not claimed on fetch");
  decode_off_a: assert property (!dec_en |=> !ls_data_sel_r && !ls_intc_sel_r &&
                                 !fetch_instr_sel_r && !ls_unclaimed_r)
    else $error("claim raised while decoding is disabled");
  read_wait_a: assert property (addr_phase && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
    else $error("read did not take exactly one wait state");
  cache_opts_a: assert property ($past(hresetn) |-> icache_present_r == ICACHE_ON &&
    icache_protect_r == (ICACHE_ON && ICACHE_PROTECT_SEL == 1))
    else $error("cache options not driven as built");
  cache_size_a: assert property (!ICACHE_ON ||
    ICACHE_CAPACITY inside {16, 32, 64, 128, 256})
    else $error("cache capacity not allowed");

  fetch_hit_c:  cover property (fetch_instr_sel_r);
  data_hit_c:   cover property (ls_data_sel_r);
  intc_hit_c:   cover property (ls_intc_sel_r);
  bus_read_c:   cover property (rd_pend_r ##1 hreadyout_r);

endmodule

// *** dv/cmmd_core_addr_model.sv ***
// model of the core fetch and load/store address paths
module cmmd_core_addr_model (
  input  wire logic        hclk,
  input  wire logic [31:0] next_fetch,
  input  wire logic [31:0] next_ls,
  output logic      [31:0] fetch_addr,
  output logic      [31:0] ls_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // address issue
  // ************************************************************
  // each requested address goes out on the edge after the request
  always_ff @(posedge hclk) begin
    fetch_addr <= next_fetch;
    ls_addr    <= next_ls;
  end
endmodule

// *** dv/cmmd_decoder_test.sv ***
// self-checking bench for the core memory map decoder
`include "cmmd_params.svh"
module cmmd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  wire         hready = hreadyout;
  logic [31:0] next_fetch;
  logic [31:0] next_ls;
  logic [31:0] fetch_addr;
  logic [31:0] ls_addr;
  // {protect, present, invalid, unclaimed, intc, data, ls instr, fetch instr}
  wire  [7:0]  da;
  wire  [7:0]  db;
  wire  [7:0]  dc;
  int          fail_count;
  int          comparisons;
  int          seed;
  logic [31:0] a;
  logic [31:0] f;
  logic [31:0] r;
  logic [31:0] rd;
  logic [31:0] rd_b;
  logic [31:0] rd_c;
  logic [4:0]  e;
  logic [31:0] hrdata_b;
  logic [31:0] hrdata_c;
  logic        hreadyout_b;
  logic        hreadyout_c;
  logic        hresp_b;
  logic        hresp_c;
  logic [31:0] corners [14] = '{32'hE000_0000, 32'hE007_FFFF, 32'hE008_0000, 32'hF003_FFFF,
    32'hF004_0000, 32'hF004_FFFF, 32'hF005_0000, 32'hFC00_0000, 32'hFC00_7FFF, 32'hFC00_8000,
    32'hD004_0000, 32'h6000_0000, 32'hF001_BFFF, 32'hF001_C000};

  // ************************************************************
  // design instances: default map, 48 KB data map, broken map
  // ************************************************************
  cmmd_decoder #(.DATA_LOCAL_MEM_OFFSET(28'h004_0000), .DATA_LOCAL_MEM_SIZE(64)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fetch_addr(fetch_addr), .ls_addr(ls_addr),
    .fetch_instr_sel(da[0]), .ls_instr_sel(da[1]), .ls_data_sel(da[2]), .ls_intc_sel(da[3]),
    .ls_unclaimed(da[4]), .cfg_invalid(da[5]), .icache_present(da[6]),
    .icache_protect_sel(da[7]));
  cmmd_decoder #(.INSTR_LOCAL_MEM_PRESENT(0), .DATA_LOCAL_MEM_OFFSET(28'h001_0000),
    .DATA_LOCAL_MEM_SIZE(48), .ICACHE_PROTECT_SEL(1)) u_dut48 (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_b),
    .hreadyout(hreadyout_b), .hresp(hresp_b), .fetch_addr(fetch_addr), .ls_addr(ls_addr),
    .fetch_instr_sel(db[0]), .ls_instr_sel(db[1]), .ls_data_sel(db[2]), .ls_intc_sel(db[3]),
    .ls_unclaimed(db[4]), .cfg_invalid(db[5]), .icache_present(db[6]),
    .icache_protect_sel(db[7]));
  // 48 KB data memory on a 32 KB boundary breaks the alignment rule
  cmmd_decoder #(.DATA_LOCAL_MEM_OFFSET(28'h000_8000), .DATA_LOCAL_MEM_SIZE(48),
    .ICACHE_PRESENT(0)) u_bad (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_c),
    .hreadyout(hreadyout_c), .hresp(hresp_c), .fetch_addr(fetch_addr), .ls_addr(ls_addr),
    .fetch_instr_sel(dc[0]), .ls_instr_sel(dc[1]), .ls_data_sel(dc[2]), .ls_intc_sel(dc[3]),
    .ls_unclaimed(dc[4]), .cfg_invalid(dc[5]), .icache_present(dc[6]),
    .icache_protect_sel(dc[7]));
  cmmd_core_addr_model u_core (
    .hclk(hclk), .next_fetch(next_fetch), .next_ls(next_ls), .fetch_addr(fetch_addr),
    .ls_addr(ls_addr));

  // ************************************************************
  // expectation functions
  // ************************************************************
  function automatic logic hit(input logic [31:0] x, input logic [3:0] rg, input int o,
                               input int kb);
    int lo;
    lo = int'(x[27:0]);
    return (x[31:28] === rg) && (lo >= o) && (lo < o + kb * 1024);
  endfunction

  function automatic logic [4:0] exp_sel(input logic [31:0] fa, input logic [31:0] la,
                                         input int doff, input int dkb, input logic ip);
    logic li;
    logic ld;
    logic lc;
    li = ip & hit(la, 4'hE, 0, 512);
    ld = hit(la, 4'hF, doff, dkb);
    lc = hit(la, 4'hF, 32'h00C0_0000, 32);
    return {~(li | ld | lc), lc, ld, li, ip & hit(fa, 4'hE, 0, 512)};
  endfunction

  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // called just after a rising edge; values seen at the falling edge hold until the next rise
  task automatic xfer(input logic [7:0] off, input logic w, input logic [31:0] wd,
                      output logic [31:0] q);
    int         n;
    logic       rdy;
    logic [4:0] st;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, off};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(negedge hclk);
      rdy = hready;
      @(posedge hclk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge hclk);
      rdy  = hready;
      q    = hrdata;
      rd_b = hrdata_b;
      rd_c = hrdata_c;
      st   = {hresp, hresp_b, hresp_c, hreadyout_b, hreadyout_c};
      @(posedge hclk);
      n++;
    end while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    chk({27'h0, st}, 32'h0000_0003);
  endtask

  // ************************************************************
  // stimulus
  // ************************************************************
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    seed = 72022;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    next_fetch = 32'h0;
    next_ls = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(`CMMD_OFF_CTRL, 1'b0, 32'h0, rd);
    chk(rd, `CMMD_CTRL_RESET);
    xfer(`CMMD_OFF_CFG_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0001);
    chk(rd_b, 32'h0000_0001);
    chk(rd_c, 32'h0000_0002);
    xfer(`CMMD_OFF_PROBE_ADDR, 1'b0, 32'h0, rd);
    chk(rd, `CMMD_PROBE_RESET);
    xfer(8'h10, 1'b1, 32'hFFFF_FFFF, rd);
    xfer(8'h10, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    chk({23'h0, da[7:5], db[7:5], dc[7:5]}, 32'h0000_00B1);
    for (int i = 0; i < 44; i++) begin
      r = $random(seed);
      a = (i < 14) ? corners[i] : {3'h7, r[31], (r[30] ? 8'h0C : 8'h00), r[19:0]};
      f = r[29] ? {4'hE, a[27:0]} : a;
      next_ls <= a;
      next_fetch <= f;
      xfer(`CMMD_OFF_PROBE_ADDR, 1'b1, a, rd);
      xfer(`CMMD_OFF_PROBE_ADDR, 1'b0, 32'h0, rd);
      chk(rd, a);
      xfer(`CMMD_OFF_PROBE_RESULT, 1'b0, 32'h0, rd);
      e = exp_sel(a, a, 32'h0004_0000, 64, 1'b1);
      chk(rd, {28'h0, e[4:1]});
      @(negedge hclk);
      chk({27'h0, da[4:0]}, {27'h0, exp_sel(f, a, 32'h0004_0000, 64, 1'b1)});
      chk({27'h0, db[4:0]}, {27'h0, exp_sel(f, a, 32'h0001_0000, 48, 1'b0)});
      chk({27'h0, dc[4:0]}, {27'h0, exp_sel(f, a, 32'h0000_8000, 48, 1'b1)});
      @(posedge hclk);
    end
    // decoding off: selects drop while the probe still answers
    xfer(`CMMD_OFF_CTRL, 1'b1, 32'h0, rd);
    next_ls <= 32'hF004_0000;
    next_fetch <= 32'hE000_0000;
    xfer(`CMMD_OFF_PROBE_ADDR, 1'b1, 32'hF004_0000, rd);
    xfer(`CMMD_OFF_PROBE_RESULT, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0002);
    @(negedge hclk);
    chk({27'h0, da[4:0]}, 32'h0);
    @(posedge hclk);
    xfer(`CMMD_OFF_CTRL, 1'b1, 32'h1, rd);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk({27'h0, da[4:0]}, 32'h0000_0005);
    // mid-run reset: claims drop, bus idles ready, control returns to its reset value
    xfer(`CMMD_OFF_CTRL, 1'b1, 32'h0, rd);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk({23'h0, hreadyout, da}, 32'h0000_0100);
    chk(hrdata, 32'h0);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(`CMMD_OFF_CTRL, 1'b0, 32'h0, rd);
    chk(rd, `CMMD_CTRL_RESET);
    finish_test();
  end
endmodule
